//--- rtl/mba_pkg.sv
// Package of register codes, field positions and shared types for the monitor block.
package mba_pkg;
   // Command codes of the two-wire interface register space.
   localparam logic [7:0] MBA_CMD_LIMIT   = 8'h11;
   localparam logic [7:0] MBA_CMD_USER    = 8'h18;
   localparam logic [7:0] MBA_CMD_FAULT   = 8'h0F;
   // Register and field widths.
   localparam int         MBA_DW          = 16;
   localparam int         MBA_LIMIT_W     = 7;
   localparam int         MBA_SRC_W       = 3;
   localparam int         MBA_RES_W       = 10;
   // Field positions in the readback word.
   localparam int         MBA_RB_SRC_LSB  = 12;
   localparam int         MBA_RB_VAL_BIT  = 10;
   localparam int         MBA_FLT_OC_BIT  = 0;
   // Limit is in 1/128 of full scale, the result in 1/1024: scale by 8.
   localparam int         MBA_LIMIT_SHIFT = 3;
   // Reset values.
   localparam logic [MBA_LIMIT_W-1:0] MBA_LIMIT_RST = 7'h00;
   localparam logic [MBA_SRC_W-1:0]   MBA_SRC_RST   = 3'h0;
   localparam logic [MBA_RES_W-1:0]   MBA_RES_RST   = 10'h000;
   localparam logic [MBA_DW-1:0]      MBA_ZERO_W    = 16'h0000;

   // Conversion sources of the user converter cycle.
   typedef enum logic [MBA_SRC_W-1:0] {
      MBA_SRC_ISRC  = 3'h0,
      MBA_SRC_IMOD  = 3'h1,
      MBA_SRC_VLD   = 3'h2,
      MBA_SRC_IMON  = 3'h3,
      MBA_SRC_TEMP  = 3'h4,
      MBA_SRC_VTERM = 3'h5,
      MBA_SRC_RSV6  = 3'h6,
      MBA_SRC_RSV7  = 3'h7
   } mba_src_e;

   // One finished user conversion as delivered by the converter.
   typedef struct packed {
      logic                 done;
      logic [MBA_SRC_W-1:0] src;
      logic [MBA_RES_W-1:0] data;
   } mba_conv_s;

   // Register access strobes from the serial interface engine.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [7:0]        cmd;
      logic [MBA_DW-1:0] wdata;
   } mba_req_s;
endpackage : mba_pkg

//--- rtl/mba_ovc_cmp.sv
// Overcurrent comparator of measured bias current against the programmed limit.
`timescale 1ns/100ps
`default_nettype none
module mba_ovc_cmp #(
   parameter int LIMIT_W = 7,
   parameter int RES_W   = 10
) (
   input  wire logic               clk,       // Controller clock.
   input  wire logic               rst_n,     // Synchronous reset, active low.
   input  wire logic [LIMIT_W-1:0] limit,     // Programmed bias limit.
   input  wire logic [RES_W-1:0]   bias_code, // Measured bias current code.
   input  wire logic               enable,    // Overcurrent detection enable.
   output logic                    over_r     // Bias above limit while enabled.
);
   import mba_pkg::*;

   logic [RES_W-1:0] thresh;

   ////////////////////////////////////////////////////////////////////////////
   // threshold scaling. Limit/128 and code/1024 share one full scale.
   assign thresh = RES_W'({limit, {MBA_LIMIT_SHIFT{1'b0}}});

   // gated comparison. Registered so the flag is glitch free.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         over_r <= 1'b0;
      end else begin
         over_r <= enable && (bias_code > thresh);
      end
   end

   a_over_cause: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 over_r == $past(enable && (int'(bias_code) * 128 > int'(limit) * 1024)))
      else $error("overcurrent level does not follow its cause");
   a_scale_check: assert property (@(posedge clk) disable iff (!rst_n)
      (enable && bias_code == {limit, 3'b000}) |=> !over_r)
      else $error("overcurrent raised at exactly the threshold");
endmodule : mba_ovc_cmp
`default_nettype wire

//--- rtl/mba_monitor.sv
// Bias limit, user converter source selection and readback registers.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Bias limit is a 7-bit unsigned field in bits 6:0, resets to zero.
// - Overcurrent fault raised when bias exceeds limit, only while detection enabled.
// - Threshold is limit/128 of the source current full scale.
// - Writing the user register stores a 3-bit source selection, reset zero.
// - Codes 0 to 5 name six sources; codes 6 and 7 are reserved.
// - Readback bits 14:12 give the source of the latest conversion.
// - Readback bits 9:0 give the latest 10-bit conversion result.
// - Fresh flag bit 10 sets on completion, clears on select write or read.
// - Overcurrent fault latches in fault bit 0, cleared by reading it.
module mba_monitor (
   input  wire logic                            clk,          // Controller clock, 40 MHz.
   input  wire logic                            rst_n,        // Synchronous reset, active low.
   input  wire mba_pkg::mba_req_s               req,          // Register access strobes.
   output logic         [mba_pkg::MBA_DW-1:0]   rdata_r,      // Read data, valid after rd.
   output logic                                 rvalid_r,     // Read data strobe.
   input  wire mba_pkg::mba_conv_s              conv,         // Finished user conversion.
   output logic         [mba_pkg::MBA_SRC_W-1:0] src_sel_r,   // Source for next user cycle.
   output logic                                 src_ok_r,     // Selection is a valid source.
   input  wire logic    [mba_pkg::MBA_RES_W-1:0] bias_code,   // Measured bias current code.
   input  wire logic                            over_cur_en,  // Overcurrent detection enable.
   output logic                                 oc_fault_r    // Latched overcurrent fault.
);
   import mba_pkg::*;

   logic [MBA_LIMIT_W-1:0] bias_current_threshold_r;
   logic [MBA_SRC_W-1:0]   last_src_r;
   logic [MBA_RES_W-1:0]   last_res_r;
   logic                   fresh_r;
   logic                   over_lvl;
   logic                   wr_limit;
   logic                   wr_user;
   logic                   rd_user;
   logic                   rd_fault;

   // Decode a command code against a strobe.
   function automatic logic hit(input logic stb, input logic [7:0] cmd,
                                input logic [7:0] code);
      hit = stb && (cmd == code);
   endfunction : hit

   // six named sources
   // Reserved source codes never reach the converter as a valid choice.
   function automatic logic src_valid(input logic [MBA_SRC_W-1:0] code);
      src_valid = (code != MBA_SRC_RSV6) && (code != MBA_SRC_RSV7);
   endfunction : src_valid

   // Read decode of the limit register.
   function automatic logic rd_limit_hit();
      rd_limit_hit = hit(req.rd, req.cmd, MBA_CMD_LIMIT);
   endfunction : rd_limit_hit

   assign wr_limit = hit(req.wr, req.cmd, MBA_CMD_LIMIT);
   assign wr_user  = hit(req.wr, req.cmd, MBA_CMD_USER);
   assign rd_user  = hit(req.rd, req.cmd, MBA_CMD_USER);
   assign rd_fault = hit(req.rd, req.cmd, MBA_CMD_FAULT);

   ////////////////////////////////////////////////////////////////////////////
   // limit register. Upper write bits are dropped, never stored.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bias_current_threshold_r <= MBA_LIMIT_RST;
      end else if (wr_limit) begin
         bias_current_threshold_r <= req.wdata[MBA_LIMIT_W-1:0];
      end
   end

   // source selection. The converter samples it at its next user cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_sel_r <= MBA_SRC_RST;
         src_ok_r  <= 1'b1;
      end else if (wr_user) begin
         src_sel_r <= req.wdata[MBA_SRC_W-1:0];
         src_ok_r  <= src_valid(req.wdata[MBA_SRC_W-1:0]);
      end
   end

   // capture source and result of each finished user conversion.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_src_r <= MBA_SRC_RST;
         last_res_r <= MBA_RES_RST;
      end else if (conv.done) begin
         last_src_r <= conv.src;
         last_res_r <= conv.data;
      end
   end

   // fresh flag. A completion in the clearing cycle wins, so no result is lost.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fresh_r <= 1'b0;
      end else if (conv.done) begin
         fresh_r <= 1'b1;
      end else if (wr_user || rd_user) begin
         fresh_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparison lives in the comparator; its registered level feeds only the sticky fault.
   mba_ovc_cmp #(
      .LIMIT_W (MBA_LIMIT_W),
      .RES_W   (MBA_RES_W)
   ) u_cmp (
      .clk       (clk),
      .rst_n     (rst_n),
      .limit     (bias_current_threshold_r),
      .bias_code (bias_code),
      .enable    (over_cur_en),
      .over_r    (over_lvl)
   );

   // sticky fault. An event in the read cycle keeps the bit set.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oc_fault_r <= 1'b0;
      end else if (over_lvl) begin
         oc_fault_r <= 1'b1;
      end else if (rd_fault) begin
         oc_fault_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux. Reserved bits and unknown codes return zero.
   // The word is registered so it stands stable for the host; the cost is
   // one cycle of read latency, which the serial engine absorbs easily.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r  <= MBA_ZERO_W;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req.rd;
         rdata_r  <= MBA_ZERO_W;
         if (rd_limit_hit()) begin
            rdata_r[MBA_LIMIT_W-1:0] <= bias_current_threshold_r;
         end else if (rd_user) begin
            rdata_r[MBA_RB_SRC_LSB +: MBA_SRC_W] <= last_src_r;
            rdata_r[MBA_RB_VAL_BIT]              <= fresh_r;
            rdata_r[MBA_RES_W-1:0]               <= last_res_r;
         end else if (rd_fault) begin
            rdata_r[MBA_FLT_OC_BIT]              <= oc_fault_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks beside the logic.
   a_limit_reset: assert property (@(posedge clk)
      !rst_n |=> bias_current_threshold_r == 7'h00)
      else $error("limit not zero after reset");
   a_limit_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_limit |=> bias_current_threshold_r == $past(req.wdata[6:0]))
      else $error("limit write not stored");
   a_src_store: assert property (@(posedge clk) disable iff (!rst_n)
      wr_user |=> src_sel_r == $past(req.wdata[2:0]))
      else $error("source selection not stored");
   a_rsv_code: assert property (@(posedge clk) disable iff (!rst_n)
      src_sel_r[2:1] == 2'b11 |-> !src_ok_r)
      else $error("reserved code marked valid");
   a_rsv_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_user && req.wdata[2:1] == 2'b11) |=> !src_ok_r)
      else $error("reserved source accepted");
   a_rb_source: assert property (@(posedge clk) disable iff (!rst_n)
      (conv.done ##1 rd_user) |=> rdata_r[14:12] == $past(conv.src, 2))
      else $error("readback source wrong");
   a_rb_result: assert property (@(posedge clk) disable iff (!rst_n)
      (conv.done ##1 rd_user) |=> rdata_r[9:0] == $past(conv.data, 2))
      else $error("readback result wrong");
   a_fresh_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ((wr_user || rd_user) && !conv.done) |=> !fresh_r)
      else $error("fresh flag not cleared");
   a_fresh_set: assert property (@(posedge clk) disable iff (!rst_n)
      conv.done |=> fresh_r ##1 (fresh_r || $past(wr_user || rd_user)))
      else $error("fresh flag lost after completion");
   a_fault_latch: assert property (@(posedge clk) disable iff (!rst_n)
      over_lvl |=> oc_fault_r)
      else $error("fault not latched");
   a_fault_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (oc_fault_r && !rd_fault) |=> oc_fault_r)
      else $error("fault dropped without read");
   a_rsv_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid_r |-> (rdata_r[15] == 1'b0 && rdata_r[11] == 1'b0))
      else $error("reserved read bit not zero");
   a_src_ok_set: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_user && req.wdata[2:1] != 2'b11) |=> src_ok_r)
      else $error("valid source marked reserved");
   a_limit_read: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd && req.cmd == MBA_CMD_LIMIT) |=> rdata_r == {9'h000, $past(bias_current_threshold_r)})
      else $error("limit readback wrong");
   a_fresh_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_user |=> rdata_r[10] == $past(fresh_r))
      else $error("readback fresh bit wrong");
   a_fault_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_fault && !over_lvl) |=> !oc_fault_r)
      else $error("fault not cleared by read");
   a_fault_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_fault |=> rdata_r == {15'h0000, $past(oc_fault_r)})
      else $error("fault readback wrong");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !rvalid_r |-> rdata_r == 16'h0000)
      else $error("read data not zero while idle");
   a_read_strobe: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd |=> rvalid_r)
      else $error("read strobe not answered");

   // Cover points of the main scenarios.
   c_fault_read: cover property (@(posedge clk) disable iff (!rst_n)
      oc_fault_r ##1 rd_fault ##1 !oc_fault_r);
   c_conv_read: cover property (@(posedge clk) disable iff (!rst_n)
      conv.done ##[1:4] rd_user);
   c_rsv_write: cover property (@(posedge clk) disable iff (!rst_n)
      wr_user && req.wdata[2:0] == 3'h7);
   c_done_clear: cover property (@(posedge clk) disable iff (!rst_n)
      conv.done && rd_user);
   c_limit_edge: cover property (@(posedge clk) disable iff (!rst_n)
      over_cur_en && bias_code == {bias_current_threshold_r, 3'b000});
endmodule : mba_monitor
`default_nettype wire

//--- sim/mba_host.sv
// Host model that issues register accesses to the monitor block.
`timescale 1ns/100ps
`default_nettype none
module mba_host (
   input  wire logic                       clk,      // Controller clock.
   output var  mba_pkg::mba_req_s          req,      // Access strobes.
   input  wire logic [mba_pkg::MBA_DW-1:0] rdata_r,  // Read data.
   input  wire logic                       rvalid_r  // Read data strobe.
);
   import mba_pkg::*;
   // Idle bus from time zero so the first edge after reset sees no access.
   initial req = '0;
   // One write, one cycle of strobe, released after the taking edge.
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask : wr
   // One read; the answer is sampled once the answering edge has settled.
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      v = rvalid_r;
      d = rdata_r;
   endtask : rd
endmodule : mba_host
`default_nettype wire

//--- sim/monitor_adc_select_and_bias_limit_tb_top.sv
// Self-checking testbench of the monitor register block.
`timescale 1ns/100ps
`default_nettype none
module monitor_adc_select_and_bias_limit_tb_top;
   import mba_pkg::*;
   logic                 clk, rst_n, rvalid_r, src_ok_r, oc_fault_r, over_cur_en;
   mba_req_s             req;
   mba_conv_s            conv;
   logic [MBA_DW-1:0]    rdata_r;
   logic [MBA_SRC_W-1:0] src_sel_r;
   logic [MBA_RES_W-1:0] bias_code;
   int                   fail_count, n_compared;

   mba_monitor mba_monitor_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata_r(rdata_r),
      .rvalid_r(rvalid_r), .conv(conv), .src_sel_r(src_sel_r), .src_ok_r(src_ok_r),
      .bias_code(bias_code), .over_cur_en(over_cur_en), .oc_fault_r(oc_fault_r));
   mba_host mba_host_inst (.clk(clk), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Read a register and judge both the strobe and the word.
   task automatic rdc(input string nm, input logic [7:0] c, input logic [15:0] e);
      logic [15:0] d;
      logic        v;
      mba_host_inst.rd(c, d, v);
      chk("rvalid", 16'h0001, {15'h0000, v});
      chk(nm, e, d);
   endtask : rdc
   // Deliver one finished conversion for a single cycle.
   task automatic conv_pulse(input logic [2:0] s, input logic [9:0] d);
      @(posedge clk);
      conv <= '{done: 1'b1, src: s, data: d};
      @(posedge clk);
      conv <= '0;
   endtask : conv_pulse
   // Wait for settled outputs after a number of edges.
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////
   // Values straight after reset.
   task automatic t_reset();
      rdc("limit", MBA_CMD_LIMIT, 16'h0000);
      rdc("user", MBA_CMD_USER, 16'h0000);
      chk("src_sel", 16'h0000, {13'h0000, src_sel_r});
   endtask : t_reset
   // Limit keeps bits 6:0 only; an unmapped code reads zero.
   task automatic t_limit();
      mba_host_inst.wr(MBA_CMD_LIMIT, 16'hFFC5);
      rdc("limit", MBA_CMD_LIMIT, 16'h0045);
      rdc("unmapped", 8'h33, 16'h0000);
   endtask : t_limit
   // Every source code, reserved upper bits set, judged at the selection outputs.
   task automatic t_src();
      for (int i = 0; i < 8; i++) begin
         mba_host_inst.wr(MBA_CMD_USER, {13'h1FFF, 3'(i)});
         settle(1);
         chk("src_sel", {13'h0000, 3'(i)}, {13'h0000, src_sel_r});
         chk("src_ok", {15'h0000, i < 6}, {15'h0000, src_ok_r});
      end
   endtask : t_src
   // Readback shows the converted source, not the written one; fresh clears.
   task automatic t_conv();
      conv_pulse(3'h2, 10'h155);
      rdc("readback", MBA_CMD_USER, 16'h2555);
      rdc("readback", MBA_CMD_USER, 16'h2155);
      conv_pulse(3'h5, 10'h3FF);
      mba_host_inst.wr(MBA_CMD_USER, 16'h0000);
      rdc("readback", MBA_CMD_USER, 16'h53FF);
   endtask : t_conv
   // Threshold is limit times eight in result units, strictly exceeded.
   task automatic t_ovc();
      mba_host_inst.wr(MBA_CMD_LIMIT, 16'h0001);
      @(posedge clk);
      bias_code <= 10'h009;
      settle(4);
      chk("fault_off", 16'h0000, {15'h0000, oc_fault_r});
      @(posedge clk);
      over_cur_en <= 1'b1;
      bias_code   <= 10'h008;
      settle(4);
      chk("fault_edge", 16'h0000, {15'h0000, oc_fault_r});
      @(posedge clk);
      bias_code <= 10'h009;
      settle(2);
      chk("fault_on", 16'h0001, {15'h0000, oc_fault_r});
      @(posedge clk);
      bias_code <= 10'h000;
      settle(3);
      rdc("fault", MBA_CMD_FAULT, 16'h0001);
      chk("fault_clr", 16'h0000, {15'h0000, oc_fault_r});
      rdc("fault", MBA_CMD_FAULT, 16'h0000);
   endtask : t_ovc

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Watchdog well beyond the roughly 80 cycles the tests need.
   initial begin
      #100000;
      fail_count++;
      results();
   end
   // Main sequence: reset for 12 cycles, then the scenarios.
   initial begin
      fail_count  = 0;
      n_compared  = 0;
      rst_n       = 1'b0;
      conv        = '0;
      bias_code   = 10'h000;
      over_cur_en = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_limit();
      t_src();
      t_conv();
      t_ovc();
      results();
   end
endmodule : monitor_adc_select_and_bias_limit_tb_top
`default_nettype wire
